//--- nps_settings_regs.sv
// Protocol settings register bank with decoded settings for the engines
// What this block does
// - TR1 code 00 is 80/fs; 01 is 64/fs slow, 32/fs fast; rest unused.
// - SOF-omission bit lets NFC-B take frames without start-of-frame.
// - EOF-omission bit lets NFC-B take frames without EOF, coherent only.
// - Preamble code selects 48, 64, 80 or 96, also for active peer.
// - Emulation FDT cut by compensation times one carrier period.
// - Target bit 3 set disables active peer frame recognition.
// - Target bit 2 set disables the automatic polling reply.
// - Target bit 0 set disables automatic NFC-A anticollision.
// - Automatic replies off: no replies, target traffic goes via FIFO.
// - Period code 000..011 gives fc/128..fc/16; top bit set is reserved.
// - CRC bypass bit set skips CRC checks; cleared, frames are checked.
// - REQA/WUPA replies and anticollision frames are never CRC checked.
// - Identifier size code 00 is 4 bytes, 01 is 7; upper bit reserved.
// - Phase clock bit picks 0 or 90 degree clock for phase measurement.
// - Correlator bit chooses correlator or pulse reception per protocol.
// - Two-bit n value feeds field-on commands; host writes it beforehand.
`timescale 1ns/1ps
module nps_settings_regs (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Register port
  input  wire nps_pkg::nps_bus_s   i_bus,
  output logic [7:0]               o_rdata,
  // Engine context
  input  wire nps_pkg::nps_proto_e i_proto,
  input  wire logic                i_slow_rate,
  input  wire logic                i_reqa_wupa_rx,
  input  wire logic                i_antcl,
  input  wire logic [11:0]         i_fdt_nominal,
  // Decoded settings
  output nps_pkg::nps_cfg_s        o_cfg
);

  logic [7:0]        regs_reg [4];
  logic [7:0]        regs_next [4];
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;
  nps_pkg::nps_cfg_s cfg_reg;
  nps_pkg::nps_cfg_s cfg_next;

  function automatic logic f_hit(input logic [7:0] addr);
    return addr >= nps_pkg::ADDR_FRAMING && addr <= nps_pkg::ADDR_AUX;
  endfunction

  function automatic logic [1:0] f_idx(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - nps_pkg::ADDR_FRAMING;
    return diff[1:0];
  endfunction

  function automatic logic [7:0] f_mask(input logic [1:0] idx);
    logic [7:0] m;
    unique case (idx)
      2'h0: m = nps_pkg::MASK_FRAMING;
      2'h1: m = nps_pkg::MASK_TARGET;
      2'h2: m = nps_pkg::MASK_STREAM;
      2'h3: m = nps_pkg::MASK_AUX;
    endcase
    return m;
  endfunction

  // Divider from the slowest rate halved once per code step
  function automatic logic [7:0] f_div(input logic [7:0] base,
                                       input logic [1:0] code);
    return base >> code;
  endfunction

  // Register writes; reserved bits are masked off
  always_comb begin
    regs_next = regs_reg;
    if (i_bus.wr && f_hit(i_bus.addr)) begin
      regs_next[f_idx(i_bus.addr)] =
        i_bus.wdata & f_mask(f_idx(i_bus.addr));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regs_reg[0] <= nps_pkg::RST_FRAMING;
      regs_reg[1] <= nps_pkg::RST_TARGET;
      regs_reg[2] <= nps_pkg::RST_STREAM;
      regs_reg[3] <= nps_pkg::RST_AUX;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // Read data stand one cycle; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (i_bus.rd && f_hit(i_bus.addr)) begin
      rdata_next = regs_reg[f_idx(i_bus.addr)];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Settings decode
  always_comb begin
    logic [7:0] fr;
    logic [7:0] tg;
    logic [7:0] st;
    logic [7:0] ax;
    logic [1:0] scf;
    logic [1:0] scp;
    logic [2:0] stx;
    logic       bpsk;
    logic       stream;
    fr = regs_reg[0];
    tg = regs_reg[1];
    st = regs_reg[2];
    ax = regs_reg[3];
    scf = st[nps_pkg::ST_SCF_LO +: 2];
    scp = st[nps_pkg::ST_SCP_LO +: 2];
    stx = st[nps_pkg::ST_STX_LO +: 3];
    bpsk = i_proto == nps_pkg::P_STREAM_BPSK;
    stream = bpsk || i_proto == nps_pkg::P_STREAM_SC;
    cfg_next = '0;
    unique case (fr[nps_pkg::FR_TR1_LO +: 2])
      2'b00: begin
        cfg_next.tr1_fs = nps_pkg::TR1_NOM_FS;
        cfg_next.tr1_ok = 1'b1;
      end
      2'b01: begin
        cfg_next.tr1_fs = i_slow_rate ? nps_pkg::TR1_SLOW_FS
                                      : nps_pkg::TR1_FAST_FS;
        cfg_next.tr1_ok = 1'b1;
      end
      default: begin
        cfg_next.tr1_fs = 8'h00;
        cfg_next.tr1_ok = 1'b0;
      end
    endcase
    cfg_next.sof_opt = fr[nps_pkg::FR_NO_SOF];
    cfg_next.preamble = nps_pkg::PRE_BASE +
      {1'b0, fr[nps_pkg::FR_PRE_LO +: 2], 4'h0};
    cfg_next.fdt_comp = tg[nps_pkg::TG_FDEL_LO +: 4];
    if (i_fdt_nominal > {8'h00, cfg_next.fdt_comp}) begin
      cfg_next.fdt_eff = i_fdt_nominal - {8'h00, cfg_next.fdt_comp};
    end else begin
      cfg_next.fdt_eff = 12'h000;
    end
    cfg_next.peer_det_en = !tg[nps_pkg::TG_PEER_OFF];
    cfg_next.auto_poll_en = !tg[nps_pkg::TG_POLL_OFF];
    cfg_next.auto_anti_en = !tg[nps_pkg::TG_ANTI_OFF];
    cfg_next.fifo_only = tg[nps_pkg::TG_POLL_OFF] &&
                         tg[nps_pkg::TG_ANTI_OFF];
    if (bpsk) begin
      cfg_next.sc_ok = scf == 2'b00;
      cfg_next.sc_div = cfg_next.sc_ok ? nps_pkg::SC_DIV_BPSK : 8'h00;
    end else begin
      cfg_next.sc_ok = 1'b1;
      cfg_next.sc_div = f_div(nps_pkg::SC_DIV_MAX, scf);
    end
    cfg_next.pulse_ok = scp[1] || bpsk;
    cfg_next.pulses = cfg_next.pulse_ok ? 4'h1 << scp : 4'h0;
    cfg_next.stx_ok = !stx[2];
    cfg_next.stx_div = cfg_next.stx_ok ?
      f_div(nps_pkg::STX_DIV_MAX, stx[1:0]) : 8'h00;
    cfg_next.crc_check = !ax[nps_pkg::AX_NO_CRC] &&
                         !i_reqa_wupa_rx && !i_antcl;
    cfg_next.id_ok = !ax[nps_pkg::AX_ID_LO + 1];
    if (!cfg_next.id_ok) begin
      cfg_next.id_bytes = 3'h0;
    end else if (ax[nps_pkg::AX_ID_LO]) begin
      cfg_next.id_bytes = nps_pkg::ID_LONG;
    end else begin
      cfg_next.id_bytes = nps_pkg::ID_SHORT;
    end
    cfg_next.phase_90 = ax[nps_pkg::AX_PHASE];
    cfg_next.field_n = ax[nps_pkg::AX_N_LO +: 2];
    // Receiver selection
    if (!ax[nps_pkg::AX_DIS_CORR]) begin
      if (!stream || (scf == 2'b01 && scp == 2'b11)) begin
        cfg_next.rx_mode = nps_pkg::RX_CORR;
      end else begin
        cfg_next.rx_mode = nps_pkg::RX_NONE;
      end
    end else begin
      unique case (i_proto)
        nps_pkg::P_NFCB: cfg_next.rx_mode = nps_pkg::RX_PULSE_COH;
        nps_pkg::P_NFCF,
        nps_pkg::P_STREAM_SC,
        nps_pkg::P_STREAM_BPSK: cfg_next.rx_mode = nps_pkg::RX_PULSE;
        default: cfg_next.rx_mode = nps_pkg::RX_NONE;
      endcase
    end
    cfg_next.eof_opt = fr[nps_pkg::FR_NO_EOF] &&
      cfg_next.rx_mode == nps_pkg::RX_PULSE_COH;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_cfg   = cfg_reg;

  // Checks start one edge after reset release, once the decode is valid
  logic chk_arm_reg;
  logic chk_arm_next;

  always_comb begin
    chk_arm_next = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_arm_reg <= 1'b0;
    end else begin
      chk_arm_reg <= chk_arm_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || !chk_arm_reg);

  sequence s_wr_aux;
    i_bus.wr && i_bus.addr == nps_pkg::ADDR_AUX;
  endsequence

  sequence s_rd_framing;
    i_bus.rd && i_bus.addr == nps_pkg::ADDR_FRAMING;
  endsequence

  AST_TR1_NOM: assert property (
    regs_reg[0][7:6] == 2'b00 |=> o_cfg.tr1_fs == 8'h50)
    else $error("TR1 code 00 not 80/fs");

  AST_TR1_FAST: assert property (
    regs_reg[0][7:6] == 2'b01 && !i_slow_rate |=> o_cfg.tr1_fs == 8'h20)
    else $error("TR1 code 01 fast rate not 32/fs");

  AST_SOF: assert property (
    regs_reg[0][5] |=> o_cfg.sof_opt)
    else $error("SOF omission not passed on");

  AST_EOF: assert property (
    o_cfg.rx_mode != nps_pkg::RX_PULSE_COH |-> !o_cfg.eof_opt)
    else $error("EOF omission outside coherent reception");

  AST_PRE: assert property (
    1'b1 |=> o_cfg.preamble ==
      7'h30 + {1'b0, $past(regs_reg[0][1:0]), 4'h0})
    else $error("Preamble length wrong");

  AST_FIFO: assert property (
    regs_reg[1][2] && regs_reg[1][0] |=> o_cfg.fifo_only &&
      !o_cfg.auto_poll_en && !o_cfg.auto_anti_en)
    else $error("Automatic reply left on in FIFO mode");

  AST_STX: assert property (
    regs_reg[2][2] |=> !o_cfg.stx_ok && o_cfg.stx_div == 8'h00)
    else $error("Reserved period code accepted");

  AST_CRC_BYP: assert property (
    (s_wr_aux and i_bus.wdata[7]) ##1 1'b1 |=> !o_cfg.crc_check)
    else $error("CRC check after bypass write");

  AST_CRC_AUTO: assert property (
    i_reqa_wupa_rx || i_antcl |=> !o_cfg.crc_check)
    else $error("CRC checked on REQA or anticollision reply");

  AST_ID: assert property (
    regs_reg[3][5:4] == 2'b01 |=> o_cfg.id_bytes == 3'h7)
    else $error("Identifier size not 7 bytes");

  AST_N: assert property (
    s_wr_aux |=> ##1 o_cfg.field_n == $past(i_bus.wdata[1:0], 2))
    else $error("Field-on n value not taken");

  AST_RSV: assert property (
    s_rd_framing |=> o_rdata[3:2] == 2'b00)
    else $error("Reserved bits read nonzero");

  AST_RD_ONE: assert property (
    !i_bus.rd |=> o_rdata == 8'h00)
    else $error("Read data held past one cycle");

  AST_TR1_SLOW: assert property (
    regs_reg[0][7:6] == 2'b01 && i_slow_rate |=> o_cfg.tr1_fs == 8'h40)
    else $error("TR1 code 01 slow rate not 64/fs");

  AST_TR1_UNUSED: assert property (
    regs_reg[0][7] |=> !o_cfg.tr1_ok && o_cfg.tr1_fs == 8'h00)
    else $error("Unused TR1 code accepted");

  AST_SOF_OFF: assert property (
    !regs_reg[0][5] |=> !o_cfg.sof_opt)
    else $error("SOF omission on while bit clear");

  AST_EOF_COH: assert property (
    regs_reg[0][4] && regs_reg[3][2] && i_proto == nps_pkg::P_NFCB
      |=> o_cfg.eof_opt)
    else $error("EOF omission lost in coherent reception");

  AST_FDT: assert property (
    i_fdt_nominal > {8'h00, regs_reg[1][7:4]} |=> o_cfg.fdt_eff ==
      $past(i_fdt_nominal) - {8'h00, $past(regs_reg[1][7:4])})
    else $error("Frame delay not shortened by compensation");

  AST_FDT_SAT: assert property (
    i_fdt_nominal <= {8'h00, regs_reg[1][7:4]} |=> o_cfg.fdt_eff == 12'h000)
    else $error("Frame delay not held at zero");

  AST_PEER: assert property (
    1'b1 |=> o_cfg.peer_det_en == !$past(regs_reg[1][3]))
    else $error("Peer frame recognition not per bit 3");

  AST_POLL: assert property (
    1'b1 |=> o_cfg.auto_poll_en == !$past(regs_reg[1][2]))
    else $error("Automatic polling reply not per bit 2");

  AST_ANTI: assert property (
    1'b1 |=> o_cfg.auto_anti_en == !$past(regs_reg[1][0]))
    else $error("Automatic anticollision not per bit 0");

  AST_SC_BPSK: assert property (
    i_proto == nps_pkg::P_STREAM_BPSK && regs_reg[2][6:5] != 2'b00
      |=> !o_cfg.sc_ok && o_cfg.sc_div == 8'h00)
    else $error("Reserved BPSK subcarrier code accepted");

  AST_PULSE_BPSK: assert property (
    i_proto != nps_pkg::P_STREAM_BPSK && !regs_reg[2][4]
      |=> !o_cfg.pulse_ok && o_cfg.pulses == 4'h0)
    else $error("BPSK-only pulse code accepted");

  AST_PULSE_8: assert property (
    regs_reg[2][4:3] == 2'b11 |=> o_cfg.pulse_ok && o_cfg.pulses == 4'h8)
    else $error("Pulse code 11 not 8 pulses");

  AST_STX_16: assert property (
    regs_reg[2][2:0] == 3'b011 |=> o_cfg.stx_ok && o_cfg.stx_div == 8'h10)
    else $error("Period code 011 not fc/16");

  AST_CRC_ON: assert property (
    !regs_reg[3][7] && !i_reqa_wupa_rx && !i_antcl |=> o_cfg.crc_check)
    else $error("CRC check dropped with bypass clear");

  AST_ID_RSV: assert property (
    regs_reg[3][5] |=> !o_cfg.id_ok && o_cfg.id_bytes == 3'h0)
    else $error("Reserved identifier size accepted");

  AST_ID_4: assert property (
    regs_reg[3][5:4] == 2'b00 |=> o_cfg.id_bytes == 3'h4)
    else $error("Identifier size not 4 bytes");

  AST_PHASE: assert property (
    1'b1 |=> o_cfg.phase_90 == $past(regs_reg[3][3]))
    else $error("Phase clock choice not passed on");

  AST_RX_CORR: assert property (
    !regs_reg[3][2] && i_proto != nps_pkg::P_STREAM_SC &&
      i_proto != nps_pkg::P_STREAM_BPSK
      |=> o_cfg.rx_mode == nps_pkg::RX_CORR)
    else $error("Correlator reception not selected");

  AST_RX_PULSE: assert property (
    regs_reg[3][2] && i_proto == nps_pkg::P_NFCF
      |=> o_cfg.rx_mode == nps_pkg::RX_PULSE)
    else $error("Pulse reception not selected for NFC-F");

  AST_RD_DATA: assert property (
    s_rd_framing |=> o_rdata == $past(regs_reg[0]))
    else $error("Read data differ from register");

  AST_WR_MASK: assert property (
    s_wr_aux |=> regs_reg[3] == ($past(i_bus.wdata) & nps_pkg::MASK_AUX))
    else $error("Write to auxiliary settings not masked");

endmodule

//--- nps_pkg.sv
// Package with addresses, fields, reset values and types of the settings bank
package nps_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_FRAMING = 8'h07;
  localparam logic [7:0] ADDR_TARGET  = 8'h08;
  localparam logic [7:0] ADDR_STREAM  = 8'h09;
  localparam logic [7:0] ADDR_AUX     = 8'h0A;
  // Reset values
  localparam logic [7:0] RST_FRAMING = 8'h00;
  localparam logic [7:0] RST_TARGET  = 8'h00;
  localparam logic [7:0] RST_STREAM  = 8'h00;
  localparam logic [7:0] RST_AUX     = 8'h00;
  // Writable bits; the others are reserved and hold zero
  localparam logic [7:0] MASK_FRAMING = 8'hF3;
  localparam logic [7:0] MASK_TARGET  = 8'hFD;
  localparam logic [7:0] MASK_STREAM  = 8'h7F;
  localparam logic [7:0] MASK_AUX     = 8'hBF;
  // Field positions
  localparam int FR_TR1_LO   = 6;
  localparam int FR_NO_SOF   = 5;
  localparam int FR_NO_EOF   = 4;
  localparam int FR_PRE_LO   = 0;
  localparam int TG_FDEL_LO  = 4;
  localparam int TG_PEER_OFF = 3;
  localparam int TG_POLL_OFF = 2;
  localparam int TG_ANTI_OFF = 0;
  localparam int ST_SCF_LO   = 5;
  localparam int ST_SCP_LO   = 3;
  localparam int ST_STX_LO   = 0;
  localparam int AX_NO_CRC   = 7;
  localparam int AX_ID_LO    = 4;
  localparam int AX_PHASE    = 3;
  localparam int AX_DIS_CORR = 2;
  localparam int AX_N_LO     = 0;
  // Timing figures in 1/fs, symbols and carrier periods; identifier sizes in bytes
  localparam logic [7:0] TR1_NOM_FS  = 8'h50;
  localparam logic [7:0] TR1_SLOW_FS = 8'h40;
  localparam logic [7:0] TR1_FAST_FS = 8'h20;
  localparam logic [6:0] PRE_BASE    = 7'h30;
  localparam logic [7:0] SC_DIV_MAX  = 8'h40;
  localparam logic [7:0] SC_DIV_BPSK = 8'h10;
  localparam logic [7:0] STX_DIV_MAX = 8'h80;
  localparam logic [2:0] ID_SHORT    = 3'h4;
  localparam logic [2:0] ID_LONG     = 3'h7;
  typedef enum logic [2:0] {
    P_NFCA, P_NFCB, P_NFCF, P_T1T, P_STREAM_SC, P_STREAM_BPSK
  } nps_proto_e;
  typedef enum logic [1:0] {
    RX_NONE, RX_CORR, RX_PULSE, RX_PULSE_COH
  } nps_rx_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } nps_bus_s;
  typedef struct packed {
    logic [7:0]  tr1_fs;
    logic        tr1_ok;
    logic        sof_opt;
    logic        eof_opt;
    logic [6:0]  preamble;
    logic [3:0]  fdt_comp;
    logic [11:0] fdt_eff;
    logic        peer_det_en;
    logic        auto_poll_en;
    logic        auto_anti_en;
    logic        fifo_only;
    logic [7:0]  sc_div;
    logic        sc_ok;
    logic [3:0]  pulses;
    logic        pulse_ok;
    logic [7:0]  stx_div;
    logic        stx_ok;
    logic        crc_check;
    logic [2:0]  id_bytes;
    logic        id_ok;
    logic        phase_90;
    nps_rx_e     rx_mode;
    logic [1:0]  field_n;
  } nps_cfg_s;
endpackage

//--- nps_engine_model.sv
// Model of the engine context around the settings bank
`timescale 1ns/1ps
module nps_engine_model (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // Commanded context
  input  wire logic          i_load,
  input  wire logic [2:0]    i_proto,
  input  wire logic [3:0]    i_flags,
  input  wire logic [11:0]   i_nom,
  // Context seen by the bank
  output nps_pkg::nps_proto_e o_proto,
  output logic               o_slow,
  output logic               o_reqa,
  output logic               o_antcl,
  output logic [11:0]        o_nom
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_proto <= nps_pkg::P_NFCA;
      o_slow  <= 1'b0;
      o_reqa  <= 1'b0;
      o_antcl <= 1'b0;
      o_nom   <= 12'h000;
    end else if (i_load) begin
      o_proto <= nps_pkg::nps_proto_e'(i_proto);
      o_slow  <= i_flags[0];
      // Anticollision frames and REQA replies exist only in NFC-A reader mode
      o_antcl <= i_flags[1] && (i_proto == 3'h0);
      o_reqa  <= i_flags[2] && (i_proto == 3'h0);
      o_nom   <= i_nom;
    end
  end
endmodule

//--- nps_settings_regs_tb.sv
// Self-checking testbench of the protocol settings bank
`timescale 1ns/1ps
module nps_settings_regs_tb;
  logic                clk;
  logic                rst_n;
  nps_pkg::nps_bus_s   bus;
  logic [7:0]          rdata;
  nps_pkg::nps_cfg_s   cfg;
  nps_pkg::nps_proto_e proto;
  logic                slow, reqa, antcl, ld;
  logic [11:0]         nom, cnom;
  logic [2:0]          cp;
  logic [3:0]          cfl;
  int                  bad_count, samples_checked;
  logic [7:0]          mk [4] = '{nps_pkg::MASK_FRAMING,
    nps_pkg::MASK_TARGET, nps_pkg::MASK_STREAM, nps_pkg::MASK_AUX};

  nps_settings_regs u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
    .o_rdata(rdata), .i_proto(proto), .i_slow_rate(slow),
    .i_reqa_wupa_rx(reqa), .i_antcl(antcl), .i_fdt_nominal(nom),
    .o_cfg(cfg));
  nps_engine_model u_eng (.i_clk(clk), .i_rst_n(rst_n), .i_load(ld),
    .i_proto(cp), .i_flags(cfl), .i_nom(cnom), .o_proto(proto),
    .o_slow(slow), .o_reqa(reqa), .o_antcl(antcl), .o_nom(nom));

  always #5 clk = ~clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [11:0] e, g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] ad, dt);
    @(posedge clk);
    bus <= '{ad, dt, 1'b1, 1'b0};
  endtask

  task automatic rd(input logic [7:0] ad, ex);
    @(posedge clk);
    bus <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("rdata", 12'(ex), 12'(rdata));
  endtask

  task automatic check_cfg(input logic [7:0] f, t, s, a,
                           input logic [2:0] p, input logic [3:0] fl,
                           input logic [11:0] nm);
    logic       st, ac, rq;
    logic [1:0] rx;
    st = p >= 3'h4;
    ac = fl[1] && p == 3'h0;
    rq = fl[2] && p == 3'h0;
    if (!a[2])
      rx = (!st || (s[6:5] == 2'h1 && s[4:3] == 2'h3)) ? 2'h1 : 2'h0;
    else
      rx = (p == 3'h1) ? 2'h3 : (p == 3'h0 || p == 3'h3) ? 2'h0 : 2'h2;
    chk("tr1_ok", 12'(!f[7]), 12'(cfg.tr1_ok));
    if (!f[7])
      chk("tr1", f[6] ? (fl[0] ? 12'h40 : 12'h20) : 12'h50,
          12'(cfg.tr1_fs));
    chk("sof", 12'(f[5]), 12'(cfg.sof_opt));
    chk("eof", 12'(f[4] && rx == 2'h3), 12'(cfg.eof_opt));
    chk("rx_mode", 12'(rx), 12'(cfg.rx_mode));
    chk("pre", 12'({f[1:0], 4'h0}) + 12'h30, 12'(cfg.preamble));
    chk("fdt", nm > 12'(t[7:4]) ? nm - 12'(t[7:4]) : 12'h0,
        cfg.fdt_eff);
    chk("fdel", 12'(t[7:4]), 12'(cfg.fdt_comp));
    chk("target", 12'({!t[3], !t[2], !t[0], t[2] & t[0]}),
        12'({cfg.peer_det_en, cfg.auto_poll_en, cfg.auto_anti_en,
             cfg.fifo_only}));
    chk("stx", 12'({!s[2], s[2] ? 8'h00 : 8'h80 >> s[1:0]}),
        12'({cfg.stx_ok, cfg.stx_div}));
    chk("crc", 12'(!a[7] && !rq && !ac), 12'(cfg.crc_check));
    chk("id", 12'({!a[5], a[5] ? 3'h0 : a[4] ? 3'h7 : 3'h4}),
        12'({cfg.id_ok, cfg.id_bytes}));
    chk("aux", 12'({a[3], a[1:0]}),
        12'({cfg.phase_90, cfg.field_n}));
    if (st) begin
      chk("sc", p == 3'h4 ? 12'({1'b1, 8'h40 >> s[6:5]}) :
          (s[6:5] == 2'h0 ? 12'h110 : 12'h000),
          12'({cfg.sc_ok, cfg.sc_div}));
      chk("pulses", (s[4] || p == 3'h5) ? 12'({1'b1, 4'h1 << s[4:3]})
          : 12'h000, 12'({cfg.pulse_ok, cfg.pulses}));
    end
  endtask

  task automatic run(input logic [7:0] f, t, s, a, input logic [2:0] p,
                     input logic [3:0] fl, input logic [11:0] nm);
    wr(8'h07, f);
    wr(8'h08, t);
    wr(8'h09, s);
    wr(8'h0A, a);
    @(posedge clk);
    bus  <= '0;
    ld   <= 1'b1;
    cp   <= p;
    cfl  <= fl;
    cnom <= nm;
    @(posedge clk);
    ld <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_cfg(f, t, s, a, p, fl, nm);
    rd(8'h09, s & nps_pkg::MASK_STREAM);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    bus = '0;
    ld = 1'b0;
    cp = 3'h0;
    cfl = 4'h0;
    cnom = 12'h000;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(29));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_cfg(8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 4'h0, 12'h000);
    for (int i = 0; i < 4; i++) rd(8'h07 + 8'(i), 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) wr(8'h07 + 8'(i), 8'hFF);
    wr(8'h0B, 8'hFF);
    for (int i = 0; i < 4; i++) rd(8'h07 + 8'(i), mk[i]);
    rd(8'h0B, 8'h00);
    rd(8'h06, 8'h00);
    $display("test reserved bits and unmapped done");
    // Recommended compensation against a nominal delay that saturates
    run(8'h40, 8'h20, 8'h38, 8'h00, 3'h4, 4'h1, 12'h001);
    for (int p = 0; p < 6; p++)
      for (int c = 0; c < 2; c++)
        run(8'h40, 8'h20, 8'h38, {5'h00, c[0], 2'h3}, 3'(p), 4'h7,
            12'hFFF);
    $display("test corner cases done");
    repeat (150)
      run(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
          3'($urandom % 6), 4'($urandom), 12'($urandom));
    $display("test random settings done");
    // Reset in mid-run must bring back the reset decode and the auxiliary register value
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_cfg(8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 4'h0, 12'h000);
    rd(8'h0A, 8'h00);
    $display("test reset in mid-run done");
    close_out;
  end
endmodule
